// File: pkg/boost_ctrl_pkg.sv
// Constants, register map and state type of the boost/pass-through control block.
// Assumes a single 25 MHz clock and a 32-bit AXI4-Lite register port.
package boost_ctrl_pkg;
   localparam int CLK_PERIOD_NS = 40;
   // Sequencer timings; least times, so cycle counts round up
   localparam int DISCHARGE_TIME_NS  = 200000;
   localparam int STARTUP_TIME_NS    = 1000000;
   localparam int DISCHARGE_CYCLES   =
      (DISCHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STARTUP_CYCLES     =
      (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAULT_PULSE_CYCLES = 8;
   localparam int TIMER_W            = 16;
   // Boost/pass-through thresholds and shutdown regulation limit, millivolts
   localparam logic [11:0] THRESH_LOW_MV  = 12'd3150;
   localparam logic [11:0] THRESH_HIGH_MV = 12'd3350;
   localparam logic [11:0] MAX_DELTA_MV   = 12'd3600;
   // Register byte offsets
   localparam int         ADDR_W         = 8;
   localparam logic [7:0] CTRL_OFF       = 8'h00;
   localparam logic [7:0] STATUS_OFF     = 8'h04;
   localparam logic [7:0] INT_STATUS_OFF = 8'h08;
   localparam logic [7:0] INT_CLEAR_OFF  = 8'h0c;
   localparam logic [7:0] INT_ENABLE_OFF = 8'h10;
   // Control fields and reset values
   localparam int         CTRL_ROLE_BIT   = 0;
   localparam int         CTRL_FSIG_BIT   = 1;
   localparam logic       ROLE_RESET_LINE = 1'b1;
   localparam logic       FSIG_RESET      = 1'b1;
   // Interrupt status layout
   localparam int         INT_W         = 4;
   localparam int         INT_FAULT_BIT = 0;
   localparam int         INT_MRST_BIT  = 1;
   localparam int         INT_PGUP_BIT  = 2;
   localparam int         INT_PGDN_BIT  = 3;
   localparam logic [3:0] INT_EN_RESET  = 4'h0;
   localparam logic [1:0] RESP_OKAY     = 2'b00;
   localparam logic [1:0] RESP_SLVERR   = 2'b10;
   typedef enum logic [1:0] {
      ST_SHUTDOWN,
      ST_STARTUP,
      ST_RUN,
      ST_DISCHARGE
   } seq_state_type;
endpackage : boost_ctrl_pkg

// File: pkg/interval_timer_if.sv
// Request/status bundle between the control core and one interval timer.
// Assumes owner and timer share aclk.
`timescale 1ns/1ps
interface interval_timer_if #(parameter int W = 16);
   logic         start;
   logic         abort;
   logic [W-1:0] count;
   logic         busy;
   logic         done;
   modport owner (output start, output abort, output count, input busy, input done);
   modport timer (input start, input abort, input count, output busy, output done);
endinterface : interval_timer_if

// File: hdl/sync2.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sync2

// File: hdl/interval_timer.sv
// Down-counting interval timer: busy for count cycles, then a done pulse.
// Assumes start is a one-cycle request; a zero count is served as one cycle.
`timescale 1ns/1ps
module interval_timer #(
   parameter int W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   interval_timer_if.timer t
);
   logic [W-1:0] cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || t.abort) begin
         cnt_q  <= '0;
         t.busy <= 1'b0;
         t.done <= 1'b0;
      end else if (t.start) begin
         cnt_q  <= (t.count == '0) ? W'(1) : t.count;
         t.busy <= 1'b1;
         t.done <= 1'b0;
      end else begin
         t.done <= (cnt_q == W'(1));
         t.busy <= (cnt_q > W'(1));
         if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
         end
      end
   end
endmodule : interval_timer

// File: hdl/boost_bypass_mode_control.sv
// Control core of a battery front-end boost/pass-through converter.
// Assumes pins and analog comparator flags are asynchronous levels; registers on AXI4-Lite.
// Functional notes
// - Enable rising edge returns the control, interrupt enable and interrupt status registers to their defaults.
// - Enable low holds shutdown and ignores all register writes.
// - In shutdown bypass pin picks forced pass-through or minimum regulation.
// - Enable high runs automatic boost/pass-through by the selected threshold.
// - Bypass pin low forces pass-through, overriding automatic boost.
// - Threshold select picks the low or high boost/pass-through threshold.
// - Shared line is mode input or reset input plus fault output.
// - Falling edge on reset line in run: discharge output, then fresh start-up.
// - Fault pulls the reset line low for a pulse, then releases.
// - Mode low: PWM heavy, pulse-skip light load; mode high forces PWM in run.
// - Power-good high only in regulation; low on fault, recovers automatically.
`timescale 1ns/1ps
module boost_bypass_mode_control
   import boost_ctrl_pkg::*;
#(
   parameter int  DISCHARGE_COUNT = DISCHARGE_CYCLES,
   parameter int  STARTUP_COUNT   = STARTUP_CYCLES,
   parameter int  FAULT_COUNT     = FAULT_PULSE_CYCLES,
   parameter logic DEFAULT_ROLE   = ROLE_RESET_LINE
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              enable,
   input  wire logic              force_passthrough_n,
   input  wire logic              threshold_select,
   input  wire logic              mode_select,
   input  wire logic              reset_fault_line_n_in,
   output logic                   reset_fault_line_n_out,
   output logic                   reset_fault_line_n_oe,
   input  wire logic              power_good_in,
   output logic                   power_good_out,
   output logic                   power_good_oe,
   input  wire logic              vin_below_threshold,
   input  wire logic              vout_in_regulation,
   input  wire logic              fault_event,
   output logic                   passthrough_on,
   output logic                   boost_on,
   output logic                   min_regulate_on,
   output logic                   discharge_on,
   output logic                   pwm_forced,
   output logic                   light_load_pulse_skip,
   output logic [11:0]            threshold_mv,
   output logic [11:0]            max_delta_mv,
   output logic                   irq
);
   generate
      if (DISCHARGE_COUNT < 1 || DISCHARGE_COUNT >= (1 << TIMER_W) ||
          STARTUP_COUNT < 1 || STARTUP_COUNT >= (1 << TIMER_W) ||
          FAULT_COUNT < 2 || FAULT_COUNT >= (1 << TIMER_W)) begin : g_bad_count
         $error("Timer counts out of range for the timer width");
      end
   endgenerate

   // Pin and comparator synchronisation
   logic [8:0] pins_s;
   logic       en_s, fpn_s, thr_s, mode_s, rfl_s, pgl_s, vlow_s, vreg_s, flt_s;
   sync2 #(.WIDTH(9)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({enable, force_passthrough_n, threshold_select, mode_select,
                 reset_fault_line_n_in, power_good_in, vin_below_threshold,
                 vout_in_regulation, fault_event}),
      .q       (pins_s)
   );
   assign {en_s, fpn_s, thr_s, mode_s, rfl_s, pgl_s, vlow_s, vreg_s, flt_s} = pins_s;

   // Edge history
   logic en_prev_q, rfl_prev_q, flt_prev_q, pg_prev_q;
   logic [2:0] own_drive_q;
   logic en_rise, rfl_fall, flt_rise;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_prev_q  <= 1'b0;
         rfl_prev_q <= 1'b0; // Synchroniser also resets low: no false fall
         flt_prev_q <= 1'b0;
      end else begin
         en_prev_q  <= en_s;
         rfl_prev_q <= rfl_s;
         flt_prev_q <= flt_s;
      end
   end
   assign en_rise  = en_s && !en_prev_q;
   assign rfl_fall = rfl_prev_q && !rfl_s;
   assign flt_rise = flt_s && !flt_prev_q;

   // Register file
   logic             role_q, fsig_q;
   logic [INT_W-1:0] int_stat_q, int_en_q, int_set;
   seq_state_type    state_q;
   logic             pg_good_q;

   // Write channel: address and data taken in either order
   logic              aw_held_q, w_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]       w_data_q;
   logic              w_strb0_q;
   logic              do_write;
   assign awready  = !aw_held_q && !bvalid;
   assign wready   = !w_held_q && !bvalid;
   assign do_write = aw_held_q && w_held_q && !bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb0_q <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held_q  <= 1'b1;
            w_data_q  <= wdata;
            w_strb0_q <= wstrb[0];
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   logic addr_ok_w;
   always_comb begin
      unique case (aw_addr_q)
         CTRL_OFF, STATUS_OFF, INT_STATUS_OFF, INT_CLEAR_OFF, INT_ENABLE_OFF: addr_ok_w = 1'b1;
         default: addr_ok_w = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= addr_ok_w ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Writes land only with enable high; the bus still completes so software never hangs
   logic wr_live;
   assign wr_live = do_write && addr_ok_w && w_strb0_q && en_s && !en_rise;

   always_ff @(posedge aclk) begin
      if (!aresetn || en_rise) begin
         role_q   <= DEFAULT_ROLE;
         fsig_q   <= FSIG_RESET;
         int_en_q <= INT_EN_RESET;
      end else if (wr_live && aw_addr_q == CTRL_OFF) begin
         role_q <= w_data_q[CTRL_ROLE_BIT];
         fsig_q <= w_data_q[CTRL_FSIG_BIT];
      end else if (wr_live && aw_addr_q == INT_ENABLE_OFF) begin
         int_en_q <= w_data_q[INT_W-1:0];
      end
   end

   // Sticky status; a set in the clearing cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn || en_rise) begin
         int_stat_q <= '0;
      end else if (wr_live && aw_addr_q == INT_CLEAR_OFF) begin
         int_stat_q <= (int_stat_q & ~w_data_q[INT_W-1:0]) | int_set;
      end else begin
         int_stat_q <= int_stat_q | int_set;
      end
   end
   assign irq = |(int_stat_q & int_en_q);

   // Read channel
   logic [31:0] rd_word;
   logic        rd_ok;
   always_comb begin
      rd_word = '0;
      rd_ok   = 1'b1;
      unique case (araddr)
         CTRL_OFF:       rd_word = {30'h0, fsig_q, role_q};
         STATUS_OFF:     rd_word = {22'h0, pgl_s, en_s, pwm_forced, boost_on,
                                    passthrough_on, pg_good_q, 2'(state_q), 2'h0};
         INT_STATUS_OFF: rd_word = {28'h0, int_stat_q};
         INT_CLEAR_OFF:  rd_word = '0;
         INT_ENABLE_OFF: rd_word = {28'h0, int_en_q};
         default:        rd_ok   = 1'b0;
      endcase
   end
   assign arready = !rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rd_word;
         rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Sequencing timers
   interval_timer_if #(.W(TIMER_W)) seq_t ();
   interval_timer_if #(.W(TIMER_W)) flt_t ();
   interval_timer #(.W(TIMER_W)) u_seq_timer (.aclk(aclk), .aresetn(aresetn), .t(seq_t));
   interval_timer #(.W(TIMER_W)) u_flt_timer (.aclk(aclk), .aresetn(aresetn), .t(flt_t));

   // Our own pulse echoes back through the synchroniser; mask it from reset detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         own_drive_q <= '0;
      end else begin
         own_drive_q <= {own_drive_q[1:0], reset_fault_line_n_oe};
      end
   end
   logic manual_reset;
   assign manual_reset = role_q && rfl_fall && !reset_fault_line_n_oe &&
                         (own_drive_q == '0);

   seq_state_type state_d;
   always_comb begin
      state_d       = state_q;
      seq_t.start   = 1'b0;
      seq_t.abort   = !en_s;
      seq_t.count   = TIMER_W'(STARTUP_COUNT);
      unique case (state_q)
         ST_SHUTDOWN: begin
            if (en_s) begin
               state_d     = ST_STARTUP;
               seq_t.start = 1'b1;
            end
         end
         ST_STARTUP: begin
            if (seq_t.done) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (manual_reset) begin
               state_d     = ST_DISCHARGE;
               seq_t.start = 1'b1;
               seq_t.count = TIMER_W'(DISCHARGE_COUNT);
            end
         end
         ST_DISCHARGE: begin
            if (seq_t.done) begin
               state_d     = ST_STARTUP;
               seq_t.start = 1'b1;
            end
         end
      endcase
      if (!en_s) begin
         state_d     = ST_SHUTDOWN;
         seq_t.start = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_SHUTDOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // Fault pulse on the shared line
   assign flt_t.start = role_q && fsig_q && en_s && flt_rise && !flt_t.busy;
   assign flt_t.abort = !role_q;
   assign flt_t.count = TIMER_W'(FAULT_COUNT);
   assign reset_fault_line_n_out = 1'b0;
   assign reset_fault_line_n_oe  = flt_t.busy;

   // Power-good and interrupt events
   logic pg_good_d;
   assign pg_good_d = (state_q == ST_RUN) && vreg_s && !flt_s;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pg_good_q <= 1'b0;
         pg_prev_q <= 1'b0;
      end else begin
         pg_good_q <= pg_good_d;
         pg_prev_q <= pg_good_q;
      end
   end
   assign power_good_out = 1'b0;
   assign power_good_oe  = !pg_good_q;
   always_comb begin
      int_set                = '0;
      int_set[INT_FAULT_BIT] = en_s && flt_rise;
      int_set[INT_MRST_BIT]  = manual_reset && (state_q == ST_RUN);
      int_set[INT_PGUP_BIT]  = pg_good_q && !pg_prev_q;
      int_set[INT_PGDN_BIT]  = !pg_good_q && pg_prev_q;
   end

   // Power-stage commands
   logic mode_lvl;
   assign mode_lvl = role_q ? mode_s : rfl_s;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         passthrough_on        <= 1'b0;
         boost_on              <= 1'b0;
         min_regulate_on       <= 1'b0;
         discharge_on          <= 1'b0;
         pwm_forced            <= 1'b0;
         light_load_pulse_skip <= 1'b0;
         threshold_mv          <= THRESH_LOW_MV;
         max_delta_mv          <= MAX_DELTA_MV;
      end else begin
         threshold_mv <= thr_s ? THRESH_HIGH_MV : THRESH_LOW_MV;
         max_delta_mv <= MAX_DELTA_MV;
         unique case (state_q)
            ST_SHUTDOWN: begin
               passthrough_on        <= !fpn_s;
               min_regulate_on       <= fpn_s;
               boost_on              <= 1'b0;
               discharge_on          <= 1'b0;
               pwm_forced            <= 1'b0;
               light_load_pulse_skip <= 1'b0;
            end
            ST_DISCHARGE: begin
               passthrough_on        <= 1'b0;
               min_regulate_on       <= 1'b0;
               boost_on              <= 1'b0;
               discharge_on          <= 1'b1;
               pwm_forced            <= 1'b0;
               light_load_pulse_skip <= 1'b0;
            end
            default: begin
               // Start-up ignores a high mode level; forced PWM waits for run
               passthrough_on        <= !fpn_s || !vlow_s;
               boost_on              <= fpn_s && vlow_s;
               min_regulate_on       <= 1'b0;
               discharge_on          <= 1'b0;
               pwm_forced            <= (state_q == ST_RUN) && mode_lvl;
               light_load_pulse_skip <= fpn_s && vlow_s &&
                                        !((state_q == ST_RUN) && mode_lvl);
            end
         endcase
      end
   end
endmodule : boost_bypass_mode_control

// File: sim/boost_ctrl_monitor.sv
// Pin-level checks on the boost/pass-through control core.
// Assumes it is bound to the core top; async pins settle within a few cycles.
`timescale 1ns/1ps
module boost_ctrl_monitor
   import boost_ctrl_pkg::*;
#(
   parameter int DISCHARGE_COUNT = DISCHARGE_CYCLES,
   parameter int FAULT_COUNT     = FAULT_PULSE_CYCLES
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        enable,
   input wire logic        force_passthrough_n,
   input wire logic        threshold_select,
   input wire logic        mode_select,
   input wire logic        fault_event,
   input wire logic        vout_in_regulation,
   input wire logic        reset_fault_line_n_oe,
   input wire logic        power_good_oe,
   input wire logic        passthrough_on,
   input wire logic        boost_on,
   input wire logic        min_regulate_on,
   input wire logic        discharge_on,
   input wire logic        pwm_forced,
   input wire logic [11:0] threshold_mv
);
   int pulse_q;
   int dis_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Run lengths, checked where the level falls
   always_ff @(posedge aclk) begin
      pulse_q <= reset_fault_line_n_oe ? pulse_q + 1 : 0;
   end
   always_ff @(posedge aclk) begin
      dis_q <= discharge_on ? dis_q + 1 : 0;
   end
   chk_shutdown_path: assert property (
      (!enable && $stable(force_passthrough_n))[*6] |->
      passthrough_on == !force_passthrough_n && min_regulate_on == force_passthrough_n)
      else $error("shutdown path wrong");
   chk_threshold_pick: assert property (
      (enable && $stable(threshold_select))[*5] |->
      threshold_mv == (threshold_select ? THRESH_HIGH_MV : THRESH_LOW_MV))
      else $error("threshold wrong");
   chk_path_exclusive: assert property (!(boost_on && passthrough_on))
      else $error("boost and pass-through together");
   chk_bypass_forced: assert property ((!force_passthrough_n)[*5] |-> !boost_on)
      else $error("boost despite forced pass-through");
   chk_fault_width: assert property (
      $fell(reset_fault_line_n_oe) |-> pulse_q == FAULT_COUNT)
      else $error("fault pulse width wrong");
   chk_pg_low: assert property (
      (fault_event || !vout_in_regulation)[*5] |-> power_good_oe)
      else $error("power good while out of regulation");
   chk_pwm_source: assert property ((!mode_select || !enable)[*6] |-> !pwm_forced)
      else $error("pwm forced without mode request");
   chk_discharge_len: assert property (
      // Timer done handshake adds one cycle
      $fell(discharge_on) |-> dis_q == DISCHARGE_COUNT + 1)
      else $error("discharge length wrong");
endmodule : boost_ctrl_monitor

bind boost_bypass_mode_control boost_ctrl_monitor #(
   .DISCHARGE_COUNT(DISCHARGE_COUNT),
   .FAULT_COUNT(FAULT_COUNT)
) i_boost_ctrl_monitor (.*);

// File: sim/host_pins_model.sv
// Host side of the control pins: mode request and manual reset pull.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module host_pins_model (
   input  wire logic aclk,
   input  wire logic want_pwm,
   input  wire logic want_reset,
   input  wire logic pg_line,
   input  wire logic shared_line,
   output logic      mode_select,
   output logic      host_pull,
   output int        fault_falls
);
   logic line_q;
   initial begin
      mode_select = 1'b0;
      host_pull   = 1'b0;
      fault_falls = 0;
      line_q      = 1'b1;
   end
   // Own pulls are not counted as device faults
   always @(posedge aclk) begin
      mode_select <= want_pwm && pg_line;
      host_pull   <= want_reset;
      line_q      <= shared_line;
      if (line_q && !shared_line && !host_pull) fault_falls <= fault_falls + 1;
   end
endmodule : host_pins_model

// File: sim/testbench.sv
// Self-checking bench for the boost/pass-through control core.
// Assumes pull-ups on the shared line and power-good line.
`timescale 1ns/1ps
module testbench;
   import boost_ctrl_pkg::*;
   localparam int DIS = 20;
   localparam int STU = 30;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, enable, force_passthrough_n;
   logic        threshold_select, vin_below_threshold, vout_in_regulation, fault_event;
   logic        want_pwm, want_reset, mode_select, host_pull, irq;
   logic        reset_fault_line_n_out, reset_fault_line_n_oe, power_good_out, power_good_oe;
   logic        passthrough_on, boost_on, min_regulate_on, discharge_on;
   logic        pwm_forced, light_load_pulse_skip;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, seed, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [11:0] threshold_mv, max_delta_mv;
   wire         reset_fault_line_n_in = ~(reset_fault_line_n_oe | host_pull);
   wire         power_good_in         = ~power_good_oe;
   int          num_errors, check_count, fault_falls;

   boost_bypass_mode_control #(.DISCHARGE_COUNT(DIS), .STARTUP_COUNT(STU))
      i_boost_bypass_mode_control (.*);
   host_pins_model i_host_pins_model (.aclk(aclk), .want_pwm(want_pwm),
      .want_reset(want_reset), .pg_line(power_good_in), .shared_line(reset_fault_line_n_in),
      .mode_select(mode_select), .host_pull(host_pull), .fault_falls(fault_falls));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [11:0] exp_thr(input logic s);
      return s ? THRESH_HIGH_MV : THRESH_LOW_MV;
   endfunction : exp_thr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axr
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_cycles

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Ceiling well above the few hundred cycles the sequence needs
   initial begin
      repeat (4000) @(posedge aclk);
      num_errors++;
      conclude();
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, enable, threshold_select} = '0;
      {vin_below_threshold, vout_in_regulation, fault_event, want_pwm, want_reset} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      force_passthrough_n = 1'b1;
      seed = 32'd29;
      wait_cycles(4);
      aresetn <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         force_passthrough_n <= i[0];
         wait_cycles(8);
         check(passthrough_on, !i[0]);
         check(min_regulate_on, i[0]);
      end
      check(max_delta_mv, MAX_DELTA_MV);
      axw(INT_ENABLE_OFF, 32'hf);
      check(r, RESP_OKAY);
      axr(INT_ENABLE_OFF);
      check(d, 32'h0);
      enable <= 1'b1;
      vout_in_regulation <= 1'b1;
      wait_cycles(STU + 12);
      axr(CTRL_OFF);
      check(d[7:0], 8'h3);
      axr(STATUS_OFF);
      check(d[3:2], 2'd2);
      check(power_good_oe, 1'b0);
      axr(8'h40);
      check(r, RESP_SLVERR);
      // Random pin mix in run
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         force_passthrough_n <= seed[0];
         vin_below_threshold <= seed[1];
         threshold_select    <= seed[2];
         wait_cycles(6);
         check(boost_on, seed[0] && seed[1]);
         check(passthrough_on, !(seed[0] && seed[1]));
         check(threshold_mv, exp_thr(seed[2]));
         check(light_load_pulse_skip, seed[0] && seed[1]);
      end
      force_passthrough_n <= 1'b1;
      vin_below_threshold <= 1'b1;
      want_pwm <= 1'b1;
      wait_cycles(8);
      check(pwm_forced, 1'b1);
      check(light_load_pulse_skip, 1'b0);
      want_pwm <= 1'b0;
      axw(INT_ENABLE_OFF, 32'h1 << INT_FAULT_BIT);
      axw(INT_CLEAR_OFF, 32'hf);
      check(irq, 1'b0);
      check(pwm_forced, 1'b0);
      fault_event <= 1'b1;
      wait_cycles(6);
      check(power_good_oe, 1'b1);
      check(irq, 1'b1);
      fault_event <= 1'b0;
      wait_cycles(14);
      check(fault_falls, 1);
      check(reset_fault_line_n_out, 1'b0);
      check(power_good_out, 1'b0);
      check(power_good_oe, 1'b0);
      axw(INT_CLEAR_OFF, 32'hf);
      check(irq, 1'b0);
      axw(INT_ENABLE_OFF, 32'h0);
      // Manual reset while the interrupt is masked
      want_reset <= 1'b1;
      wait_cycles(3);
      want_reset <= 1'b0;
      wait_cycles(6);
      check(discharge_on, 1'b1);
      wait_cycles(DIS);
      check(discharge_on, 1'b0);
      check(power_good_oe, 1'b1);
      wait_cycles(STU + 8);
      check(power_good_oe, 1'b0);
      axr(INT_STATUS_OFF);
      check(d[INT_MRST_BIT], 1'b1);
      check(irq, 1'b0);
      axw(INT_ENABLE_OFF, 32'h1 << INT_MRST_BIT);
      check(irq, 1'b1);
      enable <= 1'b0;
      wait_cycles(8);
      check(passthrough_on, 1'b0);
      enable <= 1'b1;
      wait_cycles(6);
      axr(INT_ENABLE_OFF);
      check(d, 32'h0);
      axr(INT_STATUS_OFF);
      check(d, 32'h0);
      conclude();
   end
endmodule : testbench
